// >>> shared/smtc_pkg.sv
// shared constants for the signal measurement timer control block
package smtc_pkg;
  // data and counter widths
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int CNT_W = 24;
  localparam int BYTE_W = 8;
  localparam int PRE_W = 3;

  // register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CPW_LOW = 8'h04;
  localparam logic [7:0] OFF_CPW_HIGH = 8'h08;
  localparam logic [7:0] OFF_CPW_UPPER = 8'h0C;
  localparam logic [7:0] OFF_PERIOD = 8'h10;
  localparam logic [7:0] OFF_COUNTER = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;

  // control register fields
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_HALT_BIT = 5;
  localparam int CTRL_WINDOW_SENSE_BIT = 4;
  localparam int CTRL_SIGNAL_SENSE_BIT = 3;
  localparam int CTRL_COUNT_EDGE_BIT = 2;
  localparam int CTRL_PRESCALE_LSB = 0;
  localparam int PRESCALE_W = 2;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hBF;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // interrupt status and mask fields
  localparam int IRQ_W = 2;
  localparam int IRQ_PERIOD_BIT = 0;
  localparam int IRQ_CAPTURE_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // reset values of the other state
  localparam logic [CNT_W-1:0] PERIOD_RESET = 24'hFF_FFFF;
  localparam logic [CNT_W-1:0] CAPTURE_RESET = 24'h00_0000;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> verilog/smtc_edge_detect.sv
// polarity-aware level and edge detector for one sampled timer input
`timescale 1ns/1ps
module smtc_edge_detect (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // synchronous clear while the timer is disabled
  input wire logic clear,
  // sampled input and its sense
  input wire logic level_in,
  input wire logic invert,
  // detected level and edges
  output logic active,
  output logic start_edge,
  output logic end_edge
);
  typedef struct packed {
    logic prev;
  } smtc_edge_state_t;

  smtc_edge_state_t s_reg;
  smtc_edge_state_t s_next;

  // inverted sense turns a falling edge into the start edge
  assign active = level_in ^ invert;
  assign start_edge = active & ~s_reg.prev;
  assign end_edge = ~active & s_reg.prev;

  always_comb begin
    s_next = s_reg;
    s_next.prev = clear ? 1'b0 : active;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// >>> verilog/smtc_top.sv
// signal measurement timer control, capture latch and axi4-lite register slave
// Behaviour
// - disabled timer holds internal reset, no clock request
// - disabling leaves software registers unchanged
// - counted clock at period match raises flag
// - control bit 4 sets window input sense
// - control bit 3 sets signal input sense
// - bits 1:0 select four prescale ratios
// - 24-bit captured width, read-only three bytes
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module smtc_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [smtc_pkg::DATA_W-1:0] wdata,
  input wire logic [smtc_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [smtc_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // timer inputs, sampled on aclk
  input wire logic timer_clock,
  input wire logic window_input,
  input wire logic signal_input,
  // timer outputs
  output logic clock_request,
  output logic irq
);
  import smtc_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [CNT_W-1:0] measure_period;
    logic [CNT_W-1:0] captured_width;
    logic [CNT_W-1:0] measure_counter;
    logic [PRE_W-1:0] pre_cnt;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic irq;
    logic clk_req;
    logic awready;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic wready;
    logic w_full;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } smtc_state_t;

  smtc_state_t s_reg;
  smtc_state_t s_next;

  logic enable;
  logic halt_at_period;
  logic [PRESCALE_W-1:0] prescale_select;
  logic [PRE_W-1:0] pre_mask;
  logic clk_active;
  logic clk_edge;
  logic win_active;
  logic sig_active;
  logic sig_start;
  logic sig_end;
  logic tick;
  logic counting;
  logic do_write;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign enable = s_reg.ctrl[CTRL_ENABLE_BIT];
  assign halt_at_period = s_reg.ctrl[CTRL_HALT_BIT];
  assign prescale_select = s_reg.ctrl[CTRL_PRESCALE_LSB +: PRESCALE_W];

  // detectors are cleared while disabled so a re-enable starts from a clean edge history
  smtc_edge_detect u_clock_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(~enable),
    .level_in(timer_clock),
    .invert(s_reg.ctrl[CTRL_COUNT_EDGE_BIT]),
    .active(clk_active),
    .start_edge(clk_edge),
    .end_edge()
  );

  smtc_edge_detect u_window_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(~enable),
    .level_in(window_input),
    .invert(s_reg.ctrl[CTRL_WINDOW_SENSE_BIT]),
    .active(win_active),
    .start_edge(),
    .end_edge()
  );

  smtc_edge_detect u_signal_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(~enable),
    .level_in(signal_input),
    .invert(s_reg.ctrl[CTRL_SIGNAL_SENSE_BIT]),
    .active(sig_active),
    .start_edge(sig_start),
    .end_edge(sig_end)
  );

  // ratio is 2 to the power of the prescale field, 1:1 up to 1:8
  assign pre_mask = PRE_W'((4'h1 << prescale_select) - 4'h1);
  assign tick = enable & clk_edge & ((s_reg.pre_cnt & pre_mask) == pre_mask);
  assign counting = sig_active & win_active;
  assign do_write = s_reg.aw_full & s_reg.w_full & ~s_reg.bvalid;

  always_comb begin
    s_next = s_reg;
    irq_set = '0;
    irq_clr = '0;

    // write address and data are taken independently, in either order
    if (s_reg.awready && awvalid) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = awaddr;
      s_next.awready = 1'b0;
    end
    if (s_reg.wready && wvalid) begin
      s_next.w_full = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
      s_next.wready = 1'b0;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end

    if (do_write) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      case ({s_reg.aw_addr[ADDR_W-1:2], 2'h0})
        ADDR_W'(OFF_CONTROL): begin
          if (s_reg.w_strb[0]) begin
            s_next.ctrl = s_reg.w_data[7:0] & CTRL_WRITE_MASK;
          end
        end
        ADDR_W'(OFF_PERIOD): begin
          for (int i = 0; i < CNT_W / BYTE_W; i++) begin
            if (s_reg.w_strb[i]) begin
              s_next.measure_period[i*BYTE_W +: BYTE_W] = s_reg.w_data[i*BYTE_W +: BYTE_W];
            end
          end
        end
        ADDR_W'(OFF_IRQ_STATUS): begin
          if (s_reg.w_strb[0]) begin
            irq_clr = s_reg.w_data[IRQ_W-1:0];
          end
        end
        ADDR_W'(OFF_IRQ_MASK): begin
          if (s_reg.w_strb[0]) begin
            s_next.mask = s_reg.w_data[IRQ_W-1:0];
          end
        end
        // capture bytes and the live counter ignore writes
        ADDR_W'(OFF_CPW_LOW), ADDR_W'(OFF_CPW_HIGH), ADDR_W'(OFF_CPW_UPPER),
        ADDR_W'(OFF_COUNTER): begin
          s_next.bresp = RESP_OKAY;
        end
        default: begin
          s_next.bresp = RESP_SLVERR;
        end
      endcase
    end

    // read: one outstanding, answer registered one cycle after acceptance
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
    if (s_reg.arready && arvalid) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = '0;
      case ({araddr[ADDR_W-1:2], 2'h0})
        ADDR_W'(OFF_CONTROL): s_next.rdata[7:0] = s_reg.ctrl;
        ADDR_W'(OFF_CPW_LOW): s_next.rdata[7:0] = s_reg.captured_width[7:0];
        ADDR_W'(OFF_CPW_HIGH): s_next.rdata[7:0] = s_reg.captured_width[15:8];
        ADDR_W'(OFF_CPW_UPPER): s_next.rdata[7:0] = s_reg.captured_width[23:16];
        ADDR_W'(OFF_PERIOD): s_next.rdata[CNT_W-1:0] = s_reg.measure_period;
        ADDR_W'(OFF_COUNTER): s_next.rdata[CNT_W-1:0] = s_reg.measure_counter;
        ADDR_W'(OFF_IRQ_STATUS): s_next.rdata[IRQ_W-1:0] = s_reg.status;
        ADDR_W'(OFF_IRQ_MASK): s_next.rdata[IRQ_W-1:0] = s_reg.mask;
        default: s_next.rresp = RESP_SLVERR;
      endcase
    end

    // measurement: only counter and prescaler are internal, software state is kept
    if (!enable) begin
      s_next.measure_counter = '0;
      s_next.pre_cnt = '0;
    end else begin
      if (clk_edge) begin
        s_next.pre_cnt = s_reg.pre_cnt + PRE_W'(1);
      end
      if (sig_end) begin
        // capture wins over a coincident tick; that tick is lost to the new pulse
        s_next.captured_width = s_reg.measure_counter;
        s_next.measure_counter = '0;
        irq_set[IRQ_CAPTURE_BIT] = 1'b1;
      end else if (tick && counting) begin
        if (s_reg.measure_counter == s_reg.measure_period) begin
          irq_set[IRQ_PERIOD_BIT] = 1'b1;
          if (!halt_at_period) begin
            s_next.measure_counter = '0;
          end
        end else begin
          s_next.measure_counter = s_reg.measure_counter + CNT_W'(1);
        end
      end
    end

    // a new event beats a clear in the same cycle
    s_next.status = (s_reg.status & ~irq_clr) | irq_set;
    s_next.irq = |(s_next.status & s_next.mask);
    s_next.clk_req = s_next.ctrl[CTRL_ENABLE_BIT];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.measure_period <= PERIOD_RESET;
      s_reg.captured_width <= CAPTURE_RESET;
      s_reg.status <= IRQ_RESET;
      s_reg.mask <= IRQ_RESET;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign clock_request = s_reg.clk_req;
  assign irq = s_reg.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_clock_request_off: assert property (!enable |-> !clock_request)
    else $error("clock request high while disabled");

  a_disabled_counter_zero: assert property (
    (!enable ##1 !enable) |-> s_reg.measure_counter == '0 && s_reg.pre_cnt == '0)
    else $error("internal state not held in reset while disabled");

  a_disable_keeps_regs: assert property (
    $fell(enable) |=> $stable(s_reg.captured_width) && $stable(s_reg.measure_period)
      && $stable(s_reg.status) && $stable(s_reg.mask))
    else $error("disable changed software visible state");

  a_period_match_flag: assert property (
    (tick && counting && !sig_end && s_reg.measure_counter == s_reg.measure_period)
      |=> s_reg.status[IRQ_PERIOD_BIT])
    else $error("period match did not raise flag");

  a_halt_holds_count: assert property (
    (tick && counting && !sig_end && halt_at_period
      && s_reg.measure_counter == s_reg.measure_period)
      |=> s_reg.measure_counter == $past(s_reg.measure_period))
    else $error("halted counter left the period value");

  a_wrap_to_zero: assert property (
    (tick && counting && !sig_end && !halt_at_period
      && s_reg.measure_counter == s_reg.measure_period) |=> s_reg.measure_counter == '0)
    else $error("counter did not wrap after match");

  a_count_increment: assert property (
    (tick && counting && !sig_end && s_reg.measure_counter != s_reg.measure_period)
      |=> s_reg.measure_counter == $past(s_reg.measure_counter) + CNT_W'(1))
    else $error("counted clock did not advance the counter");

  a_window_sense: assert property (
    (tick && !sig_end && window_input == s_reg.ctrl[CTRL_WINDOW_SENSE_BIT])
      |=> $stable(s_reg.measure_counter))
    else $error("counter moved while the window was inactive");

  a_signal_sense: assert property (
    (enable && $past(enable) && sig_start)
      |-> !$past(signal_input ^ s_reg.ctrl[CTRL_SIGNAL_SENSE_BIT]))
    else $error("signal start edge wrong");

  a_count_edge: assert property (
    (enable && $past(enable) && tick) |-> (timer_clock ^ s_reg.ctrl[CTRL_COUNT_EDGE_BIT])
      && !$past(timer_clock ^ s_reg.ctrl[CTRL_COUNT_EDGE_BIT]))
    else $error("counted on the wrong clock edge");

  a_prescale_one: assert property ((enable && prescale_select == 2'h0 && clk_edge) |-> tick)
    else $error("ratio one skipped a clock edge");

  a_prescale_spacing: assert property (
    (tick && prescale_select == 2'h1 && $stable(prescale_select)) |-> !$past(tick))
    else $error("ratio two ticked on back to back edges");

  a_capture_latch: assert property (
    (enable && sig_end) |=> s_reg.captured_width == $past(s_reg.measure_counter)
      && s_reg.status[IRQ_CAPTURE_BIT])
    else $error("capture latch not loaded");

  a_capture_read_only: assert property (
    !(enable && sig_end) |=> $stable(s_reg.captured_width))
    else $error("captured width changed without a capture");

  a_clock_request_on: assert property (enable |-> clock_request)
    else $error("clock request low while enabled");

  a_irq_level: assert property (irq == |(s_reg.status & s_reg.mask))
    else $error("interrupt output disagrees with status and mask");

  a_bvalid_holds: assert property ((bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
endmodule

// >>> testbench/smtc_tb_top.sv
// self-checking bench for the signal measurement timer control block
`timescale 1ns/1ps
module smtc_tb_top;
  import smtc_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0;
  logic [7:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic tclk = 0, win = 0, sig = 0;
  logic awready, wready, bvalid, arready, rvalid, clock_request, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] bq[$];
  logic [1:0] rrq[$];
  logic [31:0] rdq[$];
  int bad_count = 0, n_checks = 0, seed = 51444, tdiv = 0;

  smtc_top #(.ADDR_W(8)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .timer_clock(tclk), .window_input(win), .signal_input(sig),
    .clock_request(clock_request), .irq(irq)
  );

  always #50 aclk = ~aclk;
  // timer clock well under half the bus clock so every edge is sampled
  always @(posedge aclk) begin
    tdiv <= tdiv + 1;
    if (tdiv[0]) tclk <= ~tclk;
  end

  task cmp_data(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task cmp_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task cmp_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task hung(input string nm);
    bad_count++;
    $display("mismatch %s expected handshake seen timeout", nm);
    print_verdict;
  endtask

  // results are matched against notes in arrival order
  always @(posedge aclk) begin
    if (aresetn && bvalid && bready) begin
      cmp_resp("bresp", bq.pop_front(), bresp);
    end
    if (aresetn && rvalid && rready) begin
      cmp_resp("rresp", rrq.pop_front(), rresp);
      cmp_data("rdata", rdq.pop_front(), rdata);
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int n;
    logic pa, pw, pb;
    @(posedge aclk);
    bq.push_back(r);
    pa = 1;
    pw = 1;
    pb = 1;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while ((pa || pw || pb) && n < 100) begin
      @(posedge aclk);
      n++;
      if (pa && awready) begin
        pa = 0;
        awvalid <= 0;
      end
      if (pw && wready) begin
        pw = 0;
        wvalid <= 0;
      end
      if (pb && bvalid) begin
        pb = 0;
        bready <= 0;
      end
    end
    if (pa || pw || pb) hung("write");
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    int n;
    logic pa, pr;
    @(posedge aclk);
    rdq.push_back(e);
    rrq.push_back(r);
    pa = 1;
    pr = 1;
    n = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while ((pa || pr) && n < 100) begin
      @(posedge aclk);
      n++;
      if (pa && arready) begin
        pa = 0;
        arvalid <= 0;
      end
      if (pr && rvalid) begin
        pr = 0;
        rready <= 0;
      end
    end
    if (pa || pr) hung("read");
  endtask

  initial begin
    logic [7:0] c;
    int p;
    p = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(OFF_CONTROL, 32'h0000_0000);
    rd(OFF_PERIOD, 32'h00FF_FFFF);
    rd(OFF_CPW_LOW, 32'h0000_0000);
    rd(OFF_CPW_HIGH, 32'h0000_0000);
    rd(OFF_CPW_UPPER, 32'h0000_0000);
    rd(OFF_IRQ_STATUS, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000, RESP_SLVERR);
    wr(8'h20, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(OFF_CPW_LOW, 32'h0000_00AA);
    rd(OFF_CPW_LOW, 32'h0000_0000);
    wr(OFF_CONTROL, 32'h0000_00FF);
    rd(OFF_CONTROL, 32'h0000_00BF);
    repeat (3) @(posedge aclk);
    cmp_bit("clock_request", 1'b1, clock_request);
    wr(OFF_CONTROL, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    cmp_bit("clock_request", 1'b0, clock_request);
    wr(OFF_IRQ_MASK, 32'h0000_0001);
    // every prescale ratio, both edges and both senses, halting at a random period
    for (int i = 0; i < 4; i++) begin
      c = {3'b101, i[0], i[0], i[1], i[1:0]};
      p = 2 + ($random(seed) & 3);
      win <= i[0];
      sig <= ~i[0];
      wr(OFF_PERIOD, p);
      wr(OFF_CONTROL, {24'h00_0000, c});
      repeat (100) @(posedge aclk);
      rd(OFF_COUNTER, 32'h0000_0000);
      win <= ~i[0];
      repeat (400) @(posedge aclk);
      rd(OFF_COUNTER, p);
      rd(OFF_IRQ_STATUS, 32'h0000_0001);
      cmp_bit("irq", 1'b1, irq);
      sig <= i[0];
      repeat (10) @(posedge aclk);
      rd(OFF_CPW_LOW, p);
      rd(OFF_CPW_HIGH, 32'h0000_0000);
      rd(OFF_CPW_UPPER, 32'h0000_0000);
      rd(OFF_IRQ_STATUS, 32'h0000_0003);
      wr(OFF_IRQ_STATUS, 32'h0000_0001);
      rd(OFF_IRQ_STATUS, 32'h0000_0002);
      repeat (2) @(posedge aclk);
      cmp_bit("irq", 1'b0, irq);
      wr(OFF_IRQ_STATUS, 32'h0000_0002);
      rd(OFF_IRQ_STATUS, 32'h0000_0000);
      wr(OFF_CONTROL, 32'h0000_0000);
    end
    // free run without halt wraps and still flags, then halting freezes at the period
    win <= 1;
    sig <= 1;
    wr(OFF_CONTROL, 32'h0000_0080);
    repeat (100) @(posedge aclk);
    rd(OFF_IRQ_STATUS, 32'h0000_0001);
    cmp_bit("irq", 1'b1, irq);
    wr(OFF_CONTROL, 32'h0000_00A0);
    repeat (100) @(posedge aclk);
    rd(OFF_COUNTER, p);
    // disabling while halted at the period clears the timer but keeps the registers
    wr(OFF_CONTROL, 32'h0000_0000);
    rd(OFF_PERIOD, p);
    rd(OFF_CPW_LOW, p);
    rd(OFF_IRQ_STATUS, 32'h0000_0001);
    rd(OFF_COUNTER, 32'h0000_0000);
    cmp_bit("clock_request", 1'b0, clock_request);
    print_verdict;
  end
endmodule
